// ==== rtl/cidsf_flags.sv ====
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "cidsf_params.svh"

module cidsf_flags (
   input  wire logic        clk_i,                  // core clock, 25 MHz
   input  wire logic        rst_i,                  // synchronous reset, high
   // wishbone classic slave
   input  wire logic        cyc_i,                  // bus cycle
   input  wire logic        stb_i,                  // strobe
   input  wire logic        we_i,                   // write enable
   input  wire logic [11:0] adr_i,                  // byte address
   input  wire logic [3:0]  sel_i,                  // byte lane selects
   input  wire logic [31:0] dat_i,                  // write data
   output logic      [31:0] dat_o,                  // read data
   output logic             ack_o,                  // acknowledge
   // demodulator levels
   input  wire logic        fsk_bit_clock_i,        // recovered bit clock
   input  wire logic        fsk_bit_value_i,        // demodulated bit
   input  wire logic        fsk_carrier_present_i,  // carrier detect
   input  wire logic        tone_digit_ready_i,     // tone digit decoded
   input  wire logic        fsk_byte_ready_i,       // fsk character ready
   input  wire logic        alert_tone_qualified_i, // qualified alert tone
   input  wire logic        ring_or_reversal_i,     // ring or reversal
   // event outputs
   output logic             caller_id_event_o,      // any flag set
   output logic             irq_o                   // masked interrupt
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // register index from a byte address, valid only when word aligned
   function automatic logic [9:0] idx_of(input logic [11:0] a);
      idx_of = a[11:2];
   endfunction

   // true when the aligned address hits the given index
   function automatic logic hits(input logic [11:0] a, input logic [9:0] idx);
      hits = (a[1:0] == 2'h0) && (idx_of(a) == idx);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   cidsf_pkg::cidsf_top_st_t st_r;
   cidsf_pkg::cidsf_top_st_t st_nxt;

   logic [`CIDSF_NUM_LIVE-1:0]  live_raw;
   logic [`CIDSF_NUM_LIVE-1:0]  live_lvl;
   logic [`CIDSF_NUM_LIVE-1:0]  live_rise;
   logic [7:0]                  live_byte;
   logic [`CIDSF_NUM_FLAGS-1:0] flag_set;
   logic [`CIDSF_NUM_FLAGS-1:0] flag_clr;
   logic [`CIDSF_NUM_FLAGS-1:0] flags;
   logic [`CIDSF_NUM_FLAGS-1:0] ist_clr;
   logic [`CIDSF_NUM_FLAGS-1:0] ist;
   logic                        req;
   logic                        wr_commit;
   logic                        lane0;

   ////////////////////////////////////////////////////////////////////////////
   // gather detector levels into status order
   always_comb begin
      live_raw                              = `CIDSF_RST_LIVE;
      live_raw[`CIDSF_LS_FSK_BIT_CLOCK]     = fsk_bit_clock_i;
      live_raw[`CIDSF_LS_FSK_BIT_VALUE]     = fsk_bit_value_i;
      live_raw[`CIDSF_LS_FSK_CARRIER]       = fsk_carrier_present_i;
      live_raw[`CIDSF_LS_TONE_DIGIT_RDY]    = tone_digit_ready_i;
      live_raw[`CIDSF_LS_FSK_BYTE_RDY]      = fsk_byte_ready_i;
      live_raw[`CIDSF_LS_ALERT_TONE_QUAL]   = alert_tone_qualified_i;
      live_raw[`CIDSF_LS_RING_OR_REV]       = ring_or_reversal_i;
   end

   // synchronise all levels and find their rising edges
   cidsf_sync #(
      .W      (`CIDSF_NUM_LIVE)
   ) u_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .d_i    (live_raw),
      .lvl_o  (live_lvl),
      .rise_o (live_rise)
   );

   // live status byte: no latch, top bit reads zero
   assign live_byte = {1'b0, live_lvl};

   ////////////////////////////////////////////////////////////////////////////
   // flag set pulses from status edges
   always_comb begin
      flag_set                           = `CIDSF_RST_FLAGS;
      flag_set[`CIDSF_FG_FSK_LATCH_EDGE] = live_rise[`CIDSF_LS_FSK_BIT_CLOCK];
      flag_set[`CIDSF_FG_TONE_DIGIT]     = live_rise[`CIDSF_LS_TONE_DIGIT_RDY];
      flag_set[`CIDSF_FG_FSK_BYTE]       = live_rise[`CIDSF_LS_FSK_BYTE_RDY];
      flag_set[`CIDSF_FG_ALERT_TONE]     = live_rise[`CIDSF_LS_ALERT_TONE_QUAL];
      flag_set[`CIDSF_FG_RING]           = live_rise[`CIDSF_LS_RING_OR_REV];
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus decode; writes land on the acknowledge edge
   assign req       = cyc_i & stb_i;
   assign wr_commit = req & we_i & st_r.ack;
   assign lane0     = sel_i[0];

   // zero written to a flag bit clears it, one leaves it
   always_comb begin
      flag_clr = '0;
      if (wr_commit && lane0 && hits(adr_i, `CIDSF_IDX_EVENT_FLAGS)) begin
         flag_clr = ~dat_i[`CIDSF_NUM_FLAGS-1:0];
      end
   end

   // one written to an interrupt status bit clears it
   always_comb begin
      ist_clr = '0;
      if (wr_commit && lane0 && hits(adr_i, `CIDSF_IDX_INT_STATUS)) begin
         ist_clr = dat_i[`CIDSF_NUM_FLAGS-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // latched event flags, zero after reset
   cidsf_sticky #(
      .W     (`CIDSF_NUM_FLAGS),
      .RST   (`CIDSF_RST_FLAGS)
   ) u_flags (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .set_i (flag_set),
      .clr_i (flag_clr),
      .q_o   (flags)
   );

   // interrupt status, same layout, set by the same events
   cidsf_sticky #(
      .W     (`CIDSF_NUM_FLAGS),
      .RST   (`CIDSF_RST_INT_STAT)
   ) u_ist (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .set_i (flag_set),
      .clr_i (ist_clr),
      .q_o   (ist)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus state: acknowledge, read capture, mask register
   always_comb begin
      st_nxt     = st_r;
      st_nxt.ack = req & ~st_r.ack;
      if (req && !st_r.ack) begin
         // read data captured in the request cycle, shown with ack
         st_nxt.rdat = 8'h00;
         if (hits(adr_i, `CIDSF_IDX_LIVE_STATUS)) begin
            st_nxt.rdat = live_byte;
         end else if (hits(adr_i, `CIDSF_IDX_EVENT_FLAGS)) begin
            st_nxt.rdat = {3'h0, flags};
         end else if (hits(adr_i, `CIDSF_IDX_INT_STATUS)) begin
            st_nxt.rdat = {3'h0, ist};
         end else if (hits(adr_i, `CIDSF_IDX_INT_MASK)) begin
            st_nxt.rdat = {3'h0, st_r.int_mask};
         end
      end
      // live status has no write path at all
      if (wr_commit && lane0 && hits(adr_i, `CIDSF_IDX_INT_MASK)) begin
         st_nxt.int_mask = dat_i[`CIDSF_NUM_FLAGS-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r.ack      <= 1'b0;
         st_r.rdat     <= 8'h00;
         st_r.int_mask <= `CIDSF_RST_INT_MASK;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign ack_o             = st_r.ack;
   assign dat_o             = {24'h000000, st_r.rdat};
   assign caller_id_event_o = |flags;
   assign irq_o             = |(ist & st_r.int_mask);

endmodule

`default_nettype wire

// ==== rtl/cidsf_params.svh ====
`ifndef CIDSF_PARAMS_SVH
`define CIDSF_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// register indices; byte address is four times the index
`define CIDSF_IDX_LIVE_STATUS 10'h0b1
`define CIDSF_IDX_EVENT_FLAGS 10'h0b2
`define CIDSF_IDX_INT_STATUS  10'h0c0
`define CIDSF_IDX_INT_MASK    10'h0c1

////////////////////////////////////////////////////////////////////////////////
// live status bit positions
`define CIDSF_LS_FSK_BIT_CLOCK   6
`define CIDSF_LS_FSK_BIT_VALUE   5
`define CIDSF_LS_FSK_CARRIER     4
`define CIDSF_LS_TONE_DIGIT_RDY  3
`define CIDSF_LS_FSK_BYTE_RDY    2
`define CIDSF_LS_ALERT_TONE_QUAL 1
`define CIDSF_LS_RING_OR_REV     0
`define CIDSF_NUM_LIVE           7

////////////////////////////////////////////////////////////////////////////////
// event flag bit positions, shared by interrupt status and mask
`define CIDSF_FG_FSK_LATCH_EDGE 4
`define CIDSF_FG_TONE_DIGIT     3
`define CIDSF_FG_FSK_BYTE       2
`define CIDSF_FG_ALERT_TONE     1
`define CIDSF_FG_RING           0
`define CIDSF_NUM_FLAGS         5

////////////////////////////////////////////////////////////////////////////////
// reset values
`define CIDSF_RST_LIVE     7'h00
`define CIDSF_RST_FLAGS    5'h00
`define CIDSF_RST_INT_STAT 5'h00
`define CIDSF_RST_INT_MASK 5'h00

`endif

// ==== rtl/cidsf_pkg.sv ====
package cidsf_pkg;

   // state of the register bank top
   typedef struct packed {
      logic       ack;      // wishbone acknowledge
      logic [7:0] rdat;     // captured read byte
      logic [4:0] int_mask; // interrupt mask
   } cidsf_top_st_t;

endpackage

// ==== rtl/cidsf_sticky.sv ====
`timescale 1ns/10ps
`default_nettype none

module cidsf_sticky #(
   parameter int          W   = 5,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk_i, // core clock
   input  wire logic         rst_i, // synchronous reset
   input  wire logic [W-1:0] set_i, // hardware set pulses
   input  wire logic [W-1:0] clr_i, // software clear requests
   output logic      [W-1:0] q_o    // sticky bits
);

   typedef struct packed {
      logic [W-1:0] bits; // held flags
   } cidsf_sticky_st_t;

   cidsf_sticky_st_t st_r;
   cidsf_sticky_st_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // clear first, then set, so a set in the clear cycle survives
   always_comb begin
      st_nxt      = st_r;
      st_nxt.bits = (st_r.bits & ~clr_i) | set_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r.bits <= RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q_o = st_r.bits;

endmodule

`default_nettype wire

// ==== rtl/cidsf_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module cidsf_sync #(
   parameter int W = 7
) (
   input  wire logic         clk_i,  // core clock
   input  wire logic         rst_i,  // synchronous reset
   input  wire logic [W-1:0] d_i,    // raw detector levels
   output logic      [W-1:0] lvl_o,  // synchronised levels
   output logic      [W-1:0] rise_o  // one-cycle rising pulses
);

   typedef struct packed {
      logic [W-1:0] s1;   // first stage, read only by s2
      logic [W-1:0] s2;   // second stage
      logic [W-1:0] prev; // delayed copy for edges
   } cidsf_sync_st_t;

   cidsf_sync_st_t st_r;
   cidsf_sync_st_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // two-stage synchroniser plus edge history
   always_comb begin
      st_nxt      = st_r;
      st_nxt.s1   = d_i;
      st_nxt.s2   = st_r.s1;
      st_nxt.prev = st_r.s2;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // edges are seen only after both stages, so each rise counts once
   assign lvl_o  = st_r.s2;
   assign rise_o = st_r.s2 & ~st_r.prev;

endmodule

`default_nettype wire

// ==== tb/cidsf_det_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// detector bank; levels move only just after a clock edge
module cidsf_det_model (
   input  wire logic clk_i,                  // core clock
   output logic      fsk_bit_clock_o,        // recovered bit clock
   output logic      fsk_bit_value_o,        // demodulated bit
   output logic      fsk_carrier_present_o,  // carrier detect
   output logic      tone_digit_ready_o,     // tone digit ready
   output logic      fsk_byte_ready_o,       // character ready
   output logic      alert_tone_qualified_o, // qualified alert
   output logic      ring_or_reversal_o      // ring or reversal
);
   logic [6:0] lv = 7'h00;
   // one level per detector, in live status bit order
   assign fsk_bit_clock_o        = lv[6];
   assign fsk_bit_value_o        = lv[5];
   assign fsk_carrier_present_o  = lv[4];
   assign tone_digit_ready_o     = lv[3];
   assign fsk_byte_ready_o       = lv[2];
   assign alert_tone_qualified_o = lv[1];
   assign ring_or_reversal_o     = lv[0];
   // change one level at the next edge
   task automatic drive(input int i, input logic v);
      @(posedge clk_i);
      lv[i] <= v;
   endtask
endmodule
`default_nettype wire

// ==== tb/cidsf_flags_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
// bus answer and event behaviour seen from the top ports
module cidsf_flags_monitor (
   input wire logic        clk_i,              // core clock
   input wire logic        rst_i,              // sync reset
   input wire logic        cyc_i,              // bus cycle
   input wire logic        stb_i,              // strobe
   input wire logic        we_i,               // write enable
   input wire logic [11:0] adr_i,              // byte address
   input wire logic [31:0] dat_o,              // read data
   input wire logic        ack_o,              // acknowledge
   input wire logic        ring_or_reversal_i, // ring level
   input wire logic        caller_id_event_o,  // any flag set
   input wire logic        irq_o               // masked interrupt
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // an open request, and an open read
   sequence s_req; cyc_i && stb_i && !ack_o; endsequence
   sequence s_rd; s_req ##0 !we_i; endsequence
   property p_ack_due; s_req |=> ack_o; endproperty
   property p_ack_once; ack_o |=> !ack_o; endproperty
   property p_hi_zero; ack_o |-> dat_o[31:8] == 24'h000000; endproperty
   property p_unmapped; s_rd ##0 (adr_i < 12'h2c4) |=> dat_o == 32'h00000000; endproperty
   property p_flag_bits; s_rd ##0 (adr_i == 12'h2c8) |=> dat_o[7:5] == 3'h0; endproperty
   property p_live_bit7; s_rd ##0 (adr_i == 12'h2c4) |=> !dat_o[7]; endproperty
   property p_evt_rise; $rose(ring_or_reversal_i) |-> ##[1:4] caller_id_event_o; endproperty
   property p_evt_hold; caller_id_event_o && !(ack_o && we_i) |=> caller_id_event_o; endproperty
   property p_irq_hold; irq_o && !(ack_o && we_i) |=> irq_o; endproperty
   a_ack_due:
      assert property (p_ack_due) else $error("request not answered next cycle");
   a_ack_once:
      assert property (p_ack_once) else $error("acknowledge longer than one cycle");
   a_hi_zero:
      assert property (p_hi_zero) else $error("upper read bits not zero");
   a_unmapped:
      assert property (p_unmapped) else $error("unmapped read not zero");
   a_flag_bits:
      assert property (p_flag_bits) else $error("unused flag bits not zero");
   a_live_bit7:
      assert property (p_live_bit7) else $error("live bit 7 not zero");
   a_evt_rise:
      assert property (p_evt_rise) else $error("ring rise did not raise event");
   a_evt_hold:
      assert property (p_evt_hold) else $error("event dropped without a write");
   a_irq_hold:
      assert property (p_irq_hold) else $error("interrupt dropped without a write");
endmodule
bind cidsf_flags cidsf_flags_monitor cidsf_flags_monitor_inst (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .ring_or_reversal_i(ring_or_reversal_i),
   .caller_id_event_o(caller_id_event_o), .irq_o(irq_o));
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [11:0] adr_i = 12'h000;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h00000000;
   logic [31:0] dat_o;
   logic [31:0] rd;
   logic        ack_o;
   logic        evt;
   logic        irq;
   wire  [6:0]  lv;
   logic [7:0]  ef;
   int          num_errors  = 0;
   int          checks_done = 0;
   logic [7:0]  fl [0:6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h00, 8'h10};
   always #20 clk_i = ~clk_i;
   cidsf_flags cidsf_flags_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .fsk_bit_clock_i(lv[6]), .fsk_bit_value_i(lv[5]), .fsk_carrier_present_i(lv[4]),
      .tone_digit_ready_i(lv[3]), .fsk_byte_ready_i(lv[2]), .alert_tone_qualified_i(lv[1]),
      .ring_or_reversal_i(lv[0]), .caller_id_event_o(evt), .irq_o(irq));
   cidsf_det_model cidsf_det_model_inst (.clk_i(clk_i), .fsk_bit_clock_o(lv[6]),
      .fsk_bit_value_o(lv[5]), .fsk_carrier_present_o(lv[4]), .tone_digit_ready_o(lv[3]),
      .fsk_byte_ready_o(lv[2]), .alert_tone_qualified_o(lv[1]), .ring_or_reversal_o(lv[0]));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one classic bus cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 16);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 16) begin
         num_errors++;
         $display("[FAIL] t=%0t ack timeout got=%h exp=%h", $time, ack_o, 1'b1);
         give_verdict();
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h00000000, 4'h1);
      chk(rd, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(12'h2c8, 32'h00000000);
      rdc(12'h2c4, 32'h00000000);
      rdc(12'h300, 32'h00000000);
      rdc(12'h304, 32'h00000000);
      ef = 8'h00;
      // raise each detector alone, then drop it; flags must stick
      for (int i = 0; i < 7; i++) begin
         cidsf_det_model_inst.drive(i, 1'b1);
         repeat (3) @(posedge clk_i);
         rdc(12'h2c4, 32'h00000001 << i);
         ef = ef | fl[i];
         rdc(12'h2c8, {24'h000000, ef});
         cidsf_det_model_inst.drive(i, 1'b0);
         repeat (3) @(posedge clk_i);
      end
      chk({31'h0, evt}, 32'h00000001);
      wb(1'b1, 12'h2c4, 32'h000000ff, 4'h1);
      rdc(12'h2c4, 32'h00000000);
      // interrupt: status, mask in, clear by one
      rdc(12'h300, 32'h0000001f);
      chk({31'h0, irq}, 32'h00000000);
      wb(1'b1, 12'h304, 32'h00000002, 4'h1);
      rdc(12'h304, 32'h00000002);
      chk({31'h0, irq}, 32'h00000001);
      wb(1'b1, 12'h300, 32'h00000002, 4'h1);
      rdc(12'h300, 32'h0000001d);
      chk({31'h0, irq}, 32'h00000000);
      // flag clearing: ones keep, lane zero off ignored, zeros clear
      wb(1'b1, 12'h2c8, 32'h000000ff, 4'h1);
      rdc(12'h2c8, 32'h0000001f);
      wb(1'b1, 12'h2c8, 32'h00000000, 4'h2);
      rdc(12'h2c8, 32'h0000001f);
      wb(1'b1, 12'h2c8, 32'h0000001e, 4'h1);
      rdc(12'h2c8, 32'h0000001e);
      wb(1'b1, 12'h2c8, 32'h00000000, 4'h1);
      rdc(12'h2c8, 32'h00000000);
      chk({31'h0, evt}, 32'h00000000);
      // a ring rise whose flag set lands on the clearing write edge must survive
      cidsf_det_model_inst.drive(0, 1'b1);
      wb(1'b1, 12'h2c8, 32'h00000000, 4'h1);
      rdc(12'h2c8, 32'h00000001);
      chk({31'h0, evt}, 32'h00000001);
      cidsf_det_model_inst.drive(0, 1'b0);
      rdc(12'h2c9, 32'h00000000);
      rdc(12'h100, 32'h00000000);
      give_verdict();
   end
endmodule
`default_nettype wire
